// [cpu_operand_field_decoder.sv]
// operand field decoder with classic wishbone register slave
`timescale 1ns/10ps
module cpu_operand_field_decoder import opdec_pkg::*; (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // wishbone slave
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [31:0]      wb_dat_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic             wb_we_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  output logic                  wb_ack_o,
  output logic [31:0]           wb_dat_o,
  // datapath feedback
  input  wire logic             test_true,
  input  wire logic             flag_we,
  input  wire logic [4:0]       flag_val,
  // decoded operands
  output addr_t                 data_addr,
  output addr_t                 src_addr,
  output logic [2:0]            bit_sel,
  output logic                  result_to_file,
  output logic [19:0]           literal,
  output logic [1:0]            lit_width,
  output logic [1:0]            ptr_sel,
  // program flow
  output logic                  pc_relative,
  output tptr_t                 branch_offset,
  output logic                  shadow_save,
  output logic                  shadow_restore,
  // table access
  output tptr_t                 tbl_addr,
  output logic                  tbl_strobe,
  // state
  output logic [4:0]            status_flags,
  output logic                  decode_valid,
  output logic                  nop_exec,
  output logic                  busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    st_t                        st;
    logic [2:0]                 cnt;
    logic                       ack;
    logic [31:0]                rdat;
    word_t                      w1;
    logic [3:0]                 fmt;
    logic [3:0]                 bank;
    logic [4:0]                 flags;
    tptr_t                      tptr;
    logic [NUM_PTRS-1:0][11:0]  ptrs;
    addr_t                      daddr;
    addr_t                      saddr;
    logic [2:0]                 bsel;
    logic                       to_file;
    logic [19:0]                lit;
    logic [1:0]                 lw;
    logic [1:0]                 psel;
    logic                       rel;
    tptr_t                      boff;
    logic                       sh_save;
    logic                       sh_rest;
    tptr_t                      taddr;
    logic                       tstb;
    logic                       dvalid;
    logic                       nop;
    logic                       bad2;
  } core_t;

  localparam core_t CORE_RST = '0;

  core_t r_reg;
  core_t r_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // short form extends an 8-bit offset, long form an 11-bit one
  function automatic tptr_t sext_off(input logic [10:0] v, input logic short);
    tptr_t res;
    if (short) begin
      res = {{13{v[7]}}, v[7:0]};
    end else begin
      res = {{10{v[10]}}, v};
    end
    return res;
  endfunction : sext_off

  function automatic logic is_two(input logic [3:0] f);
    return (f == FMT_LFSR) || (f == FMT_MOVFF) || (f == FMT_CALL) ||
           (f == FMT_GOTO) || (f == FMT_INDEX);
  endfunction : is_two

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        hit_instr;
  logic        take;
  logic        nop_w;
  logic        first;
  logic        last;
  logic        do_dec;
  logic        long_op;
  logic [3:0]  fmt;
  word_t       w;
  word_t       w1;
  logic [7:0]  f8;
  logic [2:0]  bsel_w;
  logic        d_w;
  logic        sgn_w;
  logic        hit_ptr;
  logic [1:0]  ptr_idx;
  logic [31:0] rd;
  logic [31:0] mrg;
  addr_t       src_w;
  addr_t       dst_w;
  tptr_t       tacc;
  tptr_t       tnxt;

  assign req       = wb_cyc_i & wb_stb_i & ~r_reg.ack;
  assign wr        = req & wb_we_i;
  assign hit_instr = (wb_adr_i == OFS_INSTR);
  assign take      = wr & hit_instr & (r_reg.st != ST_EXEC);
  assign w         = wb_dat_i[15:0];
  assign w1        = (r_reg.st == ST_WORD2) ? r_reg.w1 : w;
  assign fmt       = (r_reg.st == ST_WORD2) ? r_reg.fmt : wb_dat_i[FMT_LO +: 4];
  assign nop_w     = (w[TOP_LO +: 4] == SECOND_TAG);
  assign first     = take & (r_reg.st == ST_IDLE) & ~nop_w & is_two(fmt);
  assign last      = take & ((r_reg.st == ST_WORD2) ? nop_w : ~first);
  assign do_dec    = last & ((r_reg.st == ST_WORD2) | ~nop_w);
  // branch, return, taken test and double words cost a second cycle
  assign long_op   = (r_reg.st == ST_WORD2) | (do_dec & ((fmt == FMT_BRA) |
                     (fmt == FMT_RET) | test_true));
  assign f8        = w[7:0];
  assign bsel_w    = w[BIT_LO +: 3];
  assign d_w       = w[D_BIT];
  assign sgn_w     = w[10];
  assign hit_ptr   = ((wb_adr_i & ~PTR_MASK) == OFS_PTR0);
  assign ptr_idx   = wb_adr_i[PTR_IDX_LO +: 2];

  // source operand: banked/access file field, or pointer plus first offset
  data_addr_former u_src (
    .ram_access (w[A_BIT]),
    .bank       (r_reg.bank),
    .file_addr  (f8),
    .indexed    (fmt == FMT_INDEX),
    .ptr        (r_reg.ptrs[INDEX_PTR]),
    .offset     (w1[6:0]),
    .addr       (src_w)
  );

  // destination of indexed moves: pointer plus second-word offset
  data_addr_former u_dst (
    .ram_access (1'b0),
    .bank       (ACCESS_LO_BANK),
    .file_addr  (f8),
    .indexed    (1'b1),
    .ptr        (r_reg.ptrs[INDEX_PTR]),
    .offset     (w[6:0]),
    .addr       (dst_w)
  );

  table_ptr_stepper u_tbl (
    .ptr    (r_reg.tptr),
    .mode   (w[1:0]),
    .access (tacc),
    .next   (tnxt)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd = '0;
    case (wb_adr_i)
      OFS_INSTR:  rd = {12'h0, r_reg.fmt, r_reg.w1};
      OFS_BANK:   rd = {28'h0, r_reg.bank};
      OFS_FLAGS:  rd = {27'h0, r_reg.flags};
      OFS_TPTR:   rd = {11'h0, r_reg.tptr};
      OFS_ADDR:   rd = {4'h0, r_reg.saddr, 4'h0, r_reg.daddr};
      OFS_CTRL:   rd = {19'h0, r_reg.st, r_reg.nop, r_reg.bad2, r_reg.psel,
                        r_reg.rel, r_reg.to_file, r_reg.bsel, r_reg.lw};
      OFS_LIT:    rd = {12'h0, r_reg.lit};
      OFS_TARGET: rd = {11'h0, r_reg.boff};
      default: begin
        if (hit_ptr) begin
          rd = {20'h0, r_reg.ptrs[ptr_idx]};
        end
      end
    endcase
  end

  assign mrg = merge(rd, wb_dat_i, wb_sel_i);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next         = r_reg;
    r_next.dvalid  = 1'b0;
    r_next.sh_save = 1'b0;
    r_next.sh_rest = 1'b0;
    r_next.tstb    = 1'b0;
    // a fetch word offered while executing is held off until idle
    r_next.ack     = req & ~(wr & hit_instr & (r_reg.st == ST_EXEC));
    r_next.rdat    = (req & ~wb_we_i) ? rd : '0;

    if (wr) begin
      case (wb_adr_i)
        OFS_BANK:   r_next.bank  = mrg[3:0];
        OFS_FLAGS:  r_next.flags = mrg[4:0];
        OFS_TPTR:   r_next.tptr  = mrg[20:0];
        default: begin
          if (hit_ptr) begin
            r_next.ptrs[ptr_idx] = mrg[11:0];
          end
        end
      endcase
    end
    // datapath update wins over a software write in the same cycle
    if (flag_we) begin
      r_next.flags = flag_val;
    end

    case (r_reg.st)
      ST_IDLE: begin
        if (first) begin
          r_next.w1  = w;
          r_next.fmt = fmt;
          r_next.st  = ST_WORD2;
        end
      end
      ST_WORD2: begin
        // a following word without the 1111 tag abandons the pair
        if (take & ~nop_w) begin
          r_next.bad2 = 1'b1;
          r_next.st   = ST_IDLE;
        end
      end
      ST_EXEC: begin
        if (r_reg.cnt == 3'h0) begin
          r_next.st = ST_IDLE;
        end else begin
          r_next.cnt = r_reg.cnt - 3'h1;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    if (last) begin
      r_next.st     = ST_EXEC;
      r_next.cnt    = long_op ? CNT_TWO : CNT_ONE;
      r_next.dvalid = 1'b1;
      r_next.nop    = ~do_dec;
      r_next.bad2   = 1'b0;
      r_next.fmt    = fmt;
      r_next.w1     = w1;
    end

    // unused field bits are never looked at
    if (do_dec) begin
      case (fmt)
        FMT_BYTE: begin
          r_next.daddr   = src_w;
          r_next.to_file = d_w;
          r_next.bsel    = '0;
        end
        FMT_BIT: begin
          r_next.daddr   = src_w;
          r_next.bsel    = bsel_w;
          r_next.to_file = 1'b1;
        end
        FMT_LIT8: begin
          r_next.lit = {12'h0, w[7:0]};
          r_next.lw  = LW8;
        end
        FMT_LFSR: begin
          r_next.psel = w1[PSEL_LO +: 2];
          r_next.lit  = {8'h0, w1[3:0], w[7:0]};
          r_next.lw   = LW12;
          r_next.ptrs[w1[PSEL_LO +: 2]] = {w1[3:0], w[7:0]};
        end
        FMT_MOVFF: begin
          r_next.saddr = w1[11:0];
          r_next.daddr = w[11:0];
        end
        FMT_CALL, FMT_GOTO: begin
          r_next.lit     = {w[11:0], w1[7:0]};
          r_next.lw      = LW20;
          r_next.rel     = 1'b0;
          r_next.boff    = {1'b0, w[11:0], w1[7:0]};
          r_next.sh_save = (fmt == FMT_CALL) & w1[S_BIT];
        end
        FMT_BRA: begin
          r_next.rel  = 1'b1;
          r_next.boff = sext_off(w[10:0], 1'b0);
        end
        FMT_BCOND: begin
          r_next.rel  = 1'b1;
          r_next.boff = sext_off(w[10:0], 1'b1);
        end
        FMT_TBL: begin
          r_next.tptr  = tnxt;
          r_next.taddr = tacc;
          r_next.tstb  = 1'b1;
        end
        FMT_RET: begin
          r_next.rel     = 1'b0;
          r_next.sh_rest = w[S_BIT];
        end
        FMT_INDEX: begin
          r_next.saddr = src_w;
          r_next.daddr = dst_w;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o       = r_reg.ack;
  assign wb_dat_o       = r_reg.rdat;
  assign data_addr      = r_reg.daddr;
  assign src_addr       = r_reg.saddr;
  assign bit_sel        = r_reg.bsel;
  assign result_to_file = r_reg.to_file;
  assign literal        = r_reg.lit;
  assign lit_width      = r_reg.lw;
  assign ptr_sel        = r_reg.psel;
  assign pc_relative    = r_reg.rel;
  assign branch_offset  = r_reg.boff;
  assign shadow_save    = r_reg.sh_save;
  assign shadow_restore = r_reg.sh_rest;
  assign tbl_addr       = r_reg.taddr;
  assign tbl_strobe     = r_reg.tstb;
  assign status_flags   = r_reg.flags;
  assign decode_valid   = r_reg.dvalid;
  assign nop_exec       = r_reg.nop;
  // low state bit is set in both busy states
  assign busy           = r_reg.st[0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_exec_short;
    (r_reg.st == ST_EXEC) [*4] ##1 (r_reg.st == ST_IDLE);
  endsequence
  sequence s_exec_long;
    (r_reg.st == ST_EXEC) [*8] ##1 (r_reg.st == ST_IDLE);
  endsequence

  a_ack_single: assert property (r_reg.ack |=> !r_reg.ack)
    else $error("ack held for more than one cycle");
  a_access_bank: assert property (do_dec && fmt == FMT_BYTE && !w[A_BIT] |=>
    data_addr == (($past(f8) < ACCESS_SPLIT) ? {ACCESS_LO_BANK, $past(f8)} : {ACCESS_HI_BANK, $past(f8)}))
    else $error("access RAM address wrong");
  a_banked_addr: assert property (do_dec && fmt == FMT_BYTE && w[A_BIT] |=>
    data_addr == {$past(r_reg.bank), $past(f8)})
    else $error("banked address wrong");
  a_bit_select: assert property (do_dec && fmt == FMT_BIT |=> bit_sel == $past(bsel_w))
    else $error("bit select wrong");
  a_dest_route: assert property (do_dec && fmt == FMT_BYTE |=> result_to_file == $past(d_w))
    else $error("destination select wrong");
  a_cycle_short: assert property (last && !long_op |=> s_exec_short)
    else $error("single cycle not four periods");
  a_cycle_long: assert property (last && long_op |=> s_exec_long)
    else $error("double cycle not eight periods");
  a_lone_second: assert property (take && r_reg.st == ST_IDLE && nop_w |=> nop_exec && decode_valid)
    else $error("lone second word not a no-op");
  a_tbl_preinc: assert property (do_dec && fmt == FMT_TBL && w[1:0] == TM_PREINC |=>
    tbl_addr == $past(r_reg.tptr) + 21'h1 && tbl_addr == r_reg.tptr)
    else $error("pre-increment wrong");
  a_shadow_save: assert property (do_dec && fmt == FMT_CALL && w1[S_BIT] |=> shadow_save ##1 !shadow_save)
    else $error("shadow save pulse wrong");
  a_flag_update: assert property (flag_we |=> status_flags == $past(flag_val))
    else $error("flags not updated");
  a_rel_branch: assert property (do_dec && fmt == FMT_BRA |=>
    pc_relative && branch_offset[20:10] == {11{$past(sgn_w)}})
    else $error("relative branch not sign extended");

endmodule : cpu_operand_field_decoder

// [opdec_pkg.sv]
// constants, formats and register map of the operand field decoder
package opdec_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int         WB_AW      = 8;
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_BANK   = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_TPTR   = 8'h0c;
  localparam logic [7:0] OFS_PTR0   = 8'h10;
  localparam logic [7:0] PTR_MASK   = 8'h0c;
  localparam logic [7:0] OFS_ADDR   = 8'h20;
  localparam logic [7:0] OFS_CTRL   = 8'h24;
  localparam logic [7:0] OFS_LIT    = 8'h28;
  localparam logic [7:0] OFS_TARGET = 8'h2c;
  localparam int         PTR_IDX_LO = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [15:0] word_t;
  typedef logic [11:0] addr_t;
  typedef logic [20:0] tptr_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WORD2 = 2'b01,
    ST_EXEC  = 2'b11
  } st_t;

  // ----------------------------------------------------------------
  // instruction word fields
  // ----------------------------------------------------------------
  localparam int         FMT_LO     = 16;
  localparam int         A_BIT      = 8;
  localparam int         D_BIT      = 9;
  localparam int         BIT_LO     = 9;
  localparam int         S_BIT      = 0;
  localparam int         PSEL_LO    = 4;
  localparam int         TOP_LO     = 12;
  localparam logic [3:0] SECOND_TAG = 4'hf;

  // format codes supplied by the fetch path with each word
  localparam logic [3:0] FMT_BYTE  = 4'h0;
  localparam logic [3:0] FMT_BIT   = 4'h1;
  localparam logic [3:0] FMT_LIT8  = 4'h2;
  localparam logic [3:0] FMT_LFSR  = 4'h3;
  localparam logic [3:0] FMT_MOVFF = 4'h4;
  localparam logic [3:0] FMT_CALL  = 4'h5;
  localparam logic [3:0] FMT_GOTO  = 4'h6;
  localparam logic [3:0] FMT_BRA   = 4'h7;
  localparam logic [3:0] FMT_BCOND = 4'h8;
  localparam logic [3:0] FMT_TBL   = 4'h9;
  localparam logic [3:0] FMT_RET   = 4'ha;
  localparam logic [3:0] FMT_INDEX = 4'hb;

  // literal width codes
  localparam logic [1:0] LW8  = 2'h0;
  localparam logic [1:0] LW12 = 2'h1;
  localparam logic [1:0] LW20 = 2'h2;

  // table pointer modes
  localparam logic [1:0] TM_KEEP    = 2'h0;
  localparam logic [1:0] TM_POSTINC = 2'h1;
  localparam logic [1:0] TM_POSTDEC = 2'h2;
  localparam logic [1:0] TM_PREINC  = 2'h3;

  // status flag bit positions (overflow_flag, digit_carry_flag among them)
  localparam int FL_CARRY       = 0;
  localparam int FL_DIGIT_CARRY = 1;
  localparam int FL_ZERO        = 2;
  localparam int FL_OVERFLOW    = 3;
  localparam int FL_NEGATIVE    = 4;

  // ----------------------------------------------------------------
  // addressing and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
  localparam int         NUM_PTRS       = 4;
  localparam logic [1:0] INDEX_PTR      = 2'h2;
  localparam int         PERIODS        = 4;
  localparam logic [2:0] CNT_ONE        = 3'(PERIODS - 1);
  localparam logic [2:0] CNT_TWO        = 3'(2 * PERIODS - 1);

endpackage : opdec_pkg

// [data_addr_former.sv]
// data memory address former for file operands
`timescale 1ns/10ps
module data_addr_former import opdec_pkg::*; (
  // file operand
  input  wire logic       ram_access,
  input  wire logic [3:0] bank,
  input  wire logic [7:0] file_addr,
  // indexed operand
  input  wire logic       indexed,
  input  wire addr_t      ptr,
  input  wire logic [6:0] offset,
  // result
  output addr_t           addr
);

  always_comb begin
    if (indexed) begin
      addr = ptr + {5'h0, offset};
    end else if (ram_access) begin
      addr = {bank, file_addr};
    end else if (file_addr < ACCESS_SPLIT) begin
      addr = {ACCESS_LO_BANK, file_addr};
    end else begin
      addr = {ACCESS_HI_BANK, file_addr};
    end
  end

endmodule : data_addr_former

// [table_ptr_stepper.sv]
// table pointer update for table reads and writes
`timescale 1ns/10ps
module table_ptr_stepper import opdec_pkg::*; (
  // pointer and mode
  input  wire tptr_t      ptr,
  input  wire logic [1:0] mode,
  // results
  output tptr_t           access,
  output tptr_t           next
);

  // full 21-bit arithmetic so the pointer wraps over the whole space
  always_comb begin
    access = ptr;
    next   = ptr;
    case (mode)
      TM_POSTINC: next = ptr + 21'h1;
      TM_POSTDEC: next = ptr - 21'h1;
      TM_PREINC: begin
        access = ptr + 21'h1;
        next   = ptr + 21'h1;
      end
      default: ;
    endcase
  end

endmodule : table_ptr_stepper

// [datapath_model.sv]
// datapath feedback model facing the decoder
`timescale 1ns/10ps
module datapath_model (
  // clock
  input  wire logic       clk,
  // bench control
  input  wire logic       skip_req,
  input  wire logic       upd_req,
  input  wire logic [4:0] upd_val,
  // toward the decoder
  output logic            test_true,
  output logic            flag_we,
  output logic [4:0]      flag_val
);
  initial begin
    test_true = 1'b0;
    flag_we   = 1'b0;
    flag_val  = 5'h00;
  end
  // flag_val toggles between updates so a stale value is never taken as fresh
  always @(posedge clk) begin
    test_true <= skip_req;
    flag_we   <= upd_req;
    flag_val  <= upd_req ? upd_val : ~flag_val;
  end
endmodule : datapath_model

// [cpu_operand_field_decoder_bench.sv]
// self-checking bench for the operand field decoder
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t mismatch got %h exp %h", $time, g, e); end end
module cpu_operand_field_decoder_bench import opdec_pkg::*;;
  logic clk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_ack_o, test_true, flag_we, result_to_file, pc_relative, shadow_save, shadow_restore;
  logic tbl_strobe, decode_valid, nop_exec, busy, dv, ss, sr, ts;
  logic skip_req = 1'b0, upd_req = 1'b0;
  logic [4:0] upd_val = 5'h00, flag_val, status_flags;
  addr_t data_addr, src_addr;
  logic [2:0] bit_sel;
  logic [19:0] literal;
  logic [1:0] lit_width, ptr_sel;
  tptr_t branch_offset, tbl_addr, tp;
  int error_cnt = 0, n_tests = 0, cyc_cnt = 0;

  always #20 clk = ~clk;
  cpu_operand_field_decoder uut (
    .clk(clk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .test_true(test_true), .flag_we(flag_we), .flag_val(flag_val), .data_addr(data_addr), .src_addr(src_addr),
    .bit_sel(bit_sel), .result_to_file(result_to_file), .literal(literal), .lit_width(lit_width),
    .ptr_sel(ptr_sel), .pc_relative(pc_relative), .branch_offset(branch_offset), .shadow_save(shadow_save),
    .shadow_restore(shadow_restore), .tbl_addr(tbl_addr), .tbl_strobe(tbl_strobe),
    .status_flags(status_flags), .decode_valid(decode_valid), .nop_exec(nop_exec), .busy(busy)
  );
  datapath_model dp (
    .clk(clk), .skip_req(skip_req), .upd_req(upd_req), .upd_val(upd_val),
    .test_true(test_true), .flag_we(flag_we), .flag_val(flag_val)
  );

  // ------------------------------------------------------------
  // bus access and closing
  // ------------------------------------------------------------
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    wb_adr_i <= a; wb_we_i <= w; wb_dat_i <= d; wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1;
    // ack and the decode pulses are taken at the rising edge that sees ack high
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    dv = decode_valid; ss = shadow_save; sr = shadow_restore; ts = tbl_strobe;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
  endtask : wb
  task automatic ins(input logic [3:0] f, input word_t w);
    wb(OFS_INSTR, 1'b1, {12'h000, f, w});
  endtask : ins
  // counts the sampled cycles that busy stays high after a decode
  task automatic chk_exec(input int e);
    int n;
    n = 0;
    while (busy === 1'b1) begin
      n++;
      @(posedge clk);
    end
    `CHK(n, e)
  endtask : chk_exec
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    ins(FMT_BYTE, 16'h0045);
    `CHK(data_addr, 12'h045)
    `CHK(result_to_file, 1'b0)
    `CHK(dv, 1'b1)
    chk_exec(PERIODS);
    wb(OFS_BANK, 1'b1, 32'h3);
    wb(OFS_BANK, 1'b0, 0);
    `CHK(q, 32'h3)
    ins(FMT_BYTE, 16'h0090);
    `CHK(data_addr, 12'hf90)
    ins(FMT_BYTE, 16'h0390);
    `CHK(data_addr, 12'h390)
    `CHK(result_to_file, 1'b1)
    wb(8'h30, 1'b0, 0);
    `CHK(q, 32'h0)
    $display("test byte done");
    for (int b = 0; b < 8; b++) begin
      ins(FMT_BIT, {4'h0, 3'(b), 9'h012});
      `CHK(bit_sel, 3'(b))
    end
    $display("test bit done");
    ins(FMT_LIT8, 16'h007f);
    `CHK(literal, 20'h0007f)
    `CHK(lit_width, LW8)
    ins(FMT_LFSR, 16'h0025);
    ins(FMT_LFSR, 16'hf0ab);
    `CHK(ptr_sel, 2'h2)
    `CHK(literal, 20'h005ab)
    `CHK(lit_width, LW12)
    wb(OFS_PTR0 + 8'h08, 1'b0, 0);
    `CHK(q, 32'h5ab)
    ins(FMT_GOTO, 16'h0034);
    ins(FMT_GOTO, 16'hf812);
    `CHK(branch_offset, 21'h081234)
    `CHK(pc_relative, 1'b0)
    for (int s = 0; s < 2; s++) begin
      ins(FMT_CALL, {15'h0012, 1'(s)});
      ins(FMT_CALL, 16'hf000);
      `CHK(ss, 1'(s))
      ins(FMT_RET, {15'h0000, 1'(s)});
      `CHK(sr, 1'(s))
    end
    ins(FMT_BRA, 16'h0400);
    `CHK(branch_offset, 21'h1ffc00)
    `CHK(pc_relative, 1'b1)
    chk_exec(2 * PERIODS);
    ins(FMT_BCOND, 16'h0080);
    `CHK(branch_offset, 21'h1fff80)
    $display("test literal and flow done");
    ins(FMT_MOVFF, 16'h0abc);
    ins(FMT_MOVFF, 16'hf123);
    `CHK(src_addr, 12'habc)
    `CHK(data_addr, 12'h123)
    ins(FMT_INDEX, 16'h007f);
    ins(FMT_INDEX, 16'hf001);
    `CHK(src_addr, 12'h62a)
    `CHK(data_addr, 12'h5ac)
    ins(FMT_BYTE, 16'hf045);
    `CHK(nop_exec, 1'b1)
    `CHK(data_addr, 12'h5ac)
    ins(FMT_MOVFF, 16'h0111);
    ins(FMT_BYTE, 16'h0045);
    wb(OFS_CTRL, 1'b0, 0);
    `CHK(q[12:9], 4'b0011)
    `CHK(data_addr, 12'h5ac)
    $display("test moves done");
    for (int m = 0; m < 4; m++) begin
      wb(OFS_TPTR, 1'b1, 32'h1fffff);
      ins(FMT_TBL, {14'h0a5c, 2'(m)});
      `CHK(ts, 1'b1)
      `CHK(tbl_addr, (m == 3) ? 21'h000000 : 21'h1fffff)
      wb(OFS_TPTR, 1'b0, 0);
      tp = (m == 0) ? 21'h1fffff : (m == 2) ? 21'h1ffffe : 21'h000000;
      `CHK(q, {11'h000, tp})
    end
    $display("test table done");
    @(posedge clk);
    upd_val <= 5'h15; upd_req <= 1'b1; skip_req <= 1'b1;
    @(posedge clk);
    upd_req <= 1'b0;
    ins(FMT_BYTE, 16'h0011);
    skip_req <= 1'b0;
    chk_exec(2 * PERIODS);
    wb(OFS_FLAGS, 1'b0, 0);
    `CHK(q, 32'h15)
    `CHK(status_flags, 5'h15)
    $display("test flags done");
    stop_test();
  end
endmodule : cpu_operand_field_decoder_bench
